// ---- rtl/bdx_pkg.sv ----
// shared constants and types for the branch and data transfer core
`default_nettype none
package bdx_pkg;
  localparam int ADDR_W = 16; // data address width
  localparam int DATA_W = 8; // working register width
  localparam int REG_N = 32; // number of working registers
  localparam int OFS_W = 7; // branch offset width, signed words
  localparam int DISP_W = 6; // unsigned displacement width
  // status flag bit positions in the flags input
  localparam int F_CARRY = 0;
  localparam int F_ZERO = 1;
  localparam int F_NEG = 2;
  localparam int F_OVF = 3;
  localparam int F_SIGN = 4;
  localparam int F_HALF = 5;
  localparam int F_TBIT = 6;
  localparam int F_IRQ = 7;
  // low register index of each pointer pair
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  // pointer pair select codes
  localparam logic [1:0] SEL_X = 2'h0;
  localparam logic [1:0] SEL_Y = 2'h1;
  localparam logic [1:0] SEL_Z = 2'h2;
  // reset values
  localparam logic [ADDR_W-1:0] SP_RESET = 16'h00ff;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  // program counter steps for one-word and two-word instructions
  localparam int PC_STEP_SHORT = 1;
  localparam int PC_STEP_LONG = 2;

  // instruction group presented to the core
  typedef enum logic [2:0] {
    op_nop = 3'h0,
    op_branch = 3'h1,
    register_copy = 3'h2,
    op_load = 3'h3,
    op_store = 3'h4,
    op_push = 3'h5,
    op_pop = 3'h6
  } bdx_op_t;

  // addressing mode of loads and stores
  typedef enum logic [2:0] {
    am_plain = 3'h0,
    am_post_inc = 3'h1,
    am_pre_dec = 3'h2,
    am_with_offset = 3'h3,
    am_direct = 3'h4
  } bdx_amode_t;

  // branch condition select
  typedef enum logic [3:0] {
    branch_carry_clear = 4'h0,
    branch_same_or_higher = 4'h1,
    branch_lower = 4'h2,
    branch_minus = 4'h3,
    branch_plus = 4'h4,
    branch_signed_ge = 4'h5,
    branch_signed_less = 4'h6,
    branch_halfcarry_set = 4'h7,
    branch_halfcarry_clear = 4'h8,
    branch_tbit_set = 4'h9,
    branch_tbit_clear = 4'ha,
    branch_overflow_set = 4'hb,
    branch_overflow_clear = 4'hc,
    branch_irq_enabled = 4'hd,
    branch_irq_disabled = 4'he
  } bdx_cond_t;

  // core states, gray along idle to second and back
  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_second = 2'b01
  } bdx_state_t;
endpackage : bdx_pkg
`default_nettype wire

// ---- rtl/bdx_agu_if.sv ----
// address and branch target request and result between core and agu
`timescale 1ns/100ps
`default_nettype none
interface bdx_agu_if #(parameter int PC_W = 16);
  bdx_pkg::bdx_op_t op; // instruction group
  bdx_pkg::bdx_amode_t mode; // addressing mode
  bdx_pkg::bdx_cond_t cond; // branch condition
  logic [bdx_pkg::ADDR_W-1:0] ptr; // selected pointer pair value
  logic [bdx_pkg::ADDR_W-1:0] sp; // stack pointer
  logic [bdx_pkg::ADDR_W-1:0] addr; // direct address operand
  logic [bdx_pkg::DISP_W-1:0] disp; // unsigned displacement
  logic [bdx_pkg::OFS_W-1:0] offset; // signed branch offset
  logic [7:0] flags; // status flags
  logic [PC_W-1:0] pc; // current program counter
  logic [bdx_pkg::ADDR_W-1:0] ea; // effective data address
  logic [bdx_pkg::ADDR_W-1:0] ptr_next; // pointer after update
  logic [bdx_pkg::ADDR_W-1:0] sp_next; // stack pointer after update
  logic [PC_W-1:0] target; // branch destination
  logic taken; // branch condition holds
  modport core (output op, mode, cond, ptr, sp, addr, disp, offset, flags,
    pc, input ea, ptr_next, sp_next, target, taken);
  modport agu (input op, mode, cond, ptr, sp, addr, disp, offset, flags,
    pc, output ea, ptr_next, sp_next, target, taken);
endinterface : bdx_agu_if
`default_nettype wire

// ---- rtl/bdx_agu.sv ----
// combinational address, pointer update and branch decision unit
`timescale 1ns/100ps
`default_nettype none
module bdx_agu #(
  parameter int PC_W = 16
) (
  bdx_agu_if.agu a
);
  // condition test over the status flags
  function automatic logic cond_holds(bdx_pkg::bdx_cond_t c,
                                      logic [7:0] f);
    logic r;
    r = 1'b0;
    unique case (c)
      bdx_pkg::branch_carry_clear: r = ~f[bdx_pkg::F_CARRY];
      bdx_pkg::branch_same_or_higher: r = ~f[bdx_pkg::F_CARRY];
      bdx_pkg::branch_lower: r = f[bdx_pkg::F_CARRY];
      bdx_pkg::branch_minus: r = f[bdx_pkg::F_NEG];
      bdx_pkg::branch_plus: r = ~f[bdx_pkg::F_NEG];
      bdx_pkg::branch_signed_ge:
        r = ~(f[bdx_pkg::F_NEG] ^ f[bdx_pkg::F_OVF]);
      bdx_pkg::branch_signed_less:
        r = f[bdx_pkg::F_NEG] ^ f[bdx_pkg::F_OVF];
      bdx_pkg::branch_halfcarry_set: r = f[bdx_pkg::F_HALF];
      bdx_pkg::branch_halfcarry_clear: r = ~f[bdx_pkg::F_HALF];
      bdx_pkg::branch_tbit_set: r = f[bdx_pkg::F_TBIT];
      bdx_pkg::branch_tbit_clear: r = ~f[bdx_pkg::F_TBIT];
      bdx_pkg::branch_overflow_set: r = f[bdx_pkg::F_OVF];
      bdx_pkg::branch_overflow_clear: r = ~f[bdx_pkg::F_OVF];
      bdx_pkg::branch_irq_enabled: r = f[bdx_pkg::F_IRQ];
      bdx_pkg::branch_irq_disabled: r = ~f[bdx_pkg::F_IRQ];
      default: r = 1'b0; // code 4'hf is unused, never taken
    endcase
    return r;
  endfunction : cond_holds

  // branch target: offset sign-extended, plus one
  always_comb begin
    a.taken = cond_holds(a.cond, a.flags);
    a.target = a.pc + PC_W'({{(PC_W-bdx_pkg::OFS_W){a.offset[
      bdx_pkg::OFS_W-1]}}, a.offset}) + PC_W'(1);
  end

  // data address and pointer updates
  always_comb begin
    a.ea = a.ptr;
    a.ptr_next = a.ptr;
    a.sp_next = a.sp;
    if (a.op == bdx_pkg::op_push) begin
      a.ea = a.sp; // write at sp, then step down
      a.sp_next = a.sp - 16'h0001;
    end else if (a.op == bdx_pkg::op_pop) begin
      a.ea = a.sp + 16'h0001; // step up first, then read
      a.sp_next = a.sp + 16'h0001;
    end else begin
      unique case (a.mode)
        bdx_pkg::am_plain: a.ea = a.ptr;
        bdx_pkg::am_post_inc: a.ptr_next = a.ptr + 16'h0001;
        bdx_pkg::am_pre_dec: begin
          a.ea = a.ptr - 16'h0001;
          a.ptr_next = a.ptr - 16'h0001;
        end
        bdx_pkg::am_with_offset:
          a.ea = a.ptr + {10'h000, a.disp};
        bdx_pkg::am_direct: a.ea = a.addr;
        default: a.ea = a.ptr; // unused mode codes act as plain
      endcase
    end
  end
endmodule : bdx_agu
`default_nettype wire

// ---- rtl/bdx_exec.sv ----
// branch and data transfer execution core with its working registers
// Notes on behaviour
// - carry branches test carry clear or set
// - minus and plus branches test negative
// - signed branches test negative xor overflow
// - half-carry branches test half-carry flag
// - transfer-bit branches test stored t flag
// - overflow branches test overflow flag
// - interrupt branches test global enable flag
// - register copy in one clock
// - post-increment load reads then bumps pointer
// - pre-decrement load drops pointer then reads
// - offset load reads pointer plus displacement
// - direct load reads address operand, two clocks
// - post-increment store writes then bumps pointer
// - pre-decrement store drops pointer then writes
// - offset store writes pointer plus displacement
// - direct store writes address operand, two clocks
// - push writes source register onto stack
// - pop reads stack top, two clocks
`timescale 1ns/100ps
`default_nettype none
module bdx_exec #(
  parameter int PC_W = 16, // program counter width
  parameter logic [PC_W-1:0] PC_RESET = '0 // program counter after reset
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic instr_valid,
  input wire bdx_pkg::bdx_op_t instr_op,
  input wire bdx_pkg::bdx_cond_t instr_cond,
  input wire bdx_pkg::bdx_amode_t instr_mode,
  input wire logic [1:0] instr_ptr,
  input wire logic [4:0] instr_rd,
  input wire logic [4:0] instr_rr,
  input wire logic [bdx_pkg::DISP_W-1:0] instr_disp,
  input wire logic [bdx_pkg::ADDR_W-1:0] instr_addr,
  input wire logic [bdx_pkg::OFS_W-1:0] instr_offset,
  input wire logic [7:0] flags,
  input wire logic [bdx_pkg::DATA_W-1:0] mem_rdata,
  input wire logic rf_wr_en,
  input wire logic [4:0] rf_wr_addr,
  input wire logic [bdx_pkg::DATA_W-1:0] rf_wr_data,
  input wire logic [4:0] rf_rd_addr,
  output logic instr_ready,
  output logic done,
  output logic [PC_W-1:0] pc,
  output logic [bdx_pkg::ADDR_W-1:0] sp,
  output logic [bdx_pkg::ADDR_W-1:0] mem_addr,
  output logic [bdx_pkg::DATA_W-1:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  output logic [bdx_pkg::DATA_W-1:0] rf_rd_data
);
  // the pc must hold at least the sign-extended offset
  if (PC_W < bdx_pkg::OFS_W + 1 || PC_W > 32) begin : g_pc_w_check
    $error("PC_W must lie between OFS_W+1 and 32");
  end

  // working registers, pointer pairs live in the top six
  logic [bdx_pkg::DATA_W-1:0] regs [bdx_pkg::REG_N];
  logic [bdx_pkg::DATA_W-1:0] next_regs [bdx_pkg::REG_N];
  bdx_pkg::bdx_state_t state; // sequencing state
  bdx_pkg::bdx_state_t next_state;
  bdx_pkg::bdx_op_t held_op; // group running its second clock
  bdx_pkg::bdx_op_t next_held_op;
  logic [4:0] held_rd; // destination kept for the load data
  logic [4:0] next_held_rd;
  logic [PC_W-1:0] held_target; // taken branch destination
  logic [PC_W-1:0] next_held_target;
  logic next_ready;
  logic next_done;
  logic [PC_W-1:0] next_pc;
  logic [bdx_pkg::ADDR_W-1:0] next_sp;
  logic [bdx_pkg::ADDR_W-1:0] next_mem_addr;
  logic [bdx_pkg::DATA_W-1:0] next_mem_wdata;
  logic next_mem_we;
  logic next_mem_re;
  logic [bdx_pkg::DATA_W-1:0] next_rf_rd_data;
  logic accept; // request taken this clock
  logic [4:0] ptr_lo; // low register of selected pointer
  logic uses_ptr; // load or store through a pointer pair

  bdx_agu_if #(.PC_W(PC_W)) agu_bus ();

  // maps a pointer select code to its low register index
  function automatic logic [4:0] ptr_base(logic [1:0] sel);
    logic [4:0] r;
    r = bdx_pkg::PTR_X_LO;
    unique case (sel)
      bdx_pkg::SEL_X: r = bdx_pkg::PTR_X_LO;
      bdx_pkg::SEL_Y: r = bdx_pkg::PTR_Y_LO;
      bdx_pkg::SEL_Z: r = bdx_pkg::PTR_Z_LO;
      default: r = bdx_pkg::PTR_Z_LO; // code 3 is unused, falls on z
    endcase
    return r;
  endfunction : ptr_base

  // step of the pc after a one-word or two-word instruction
  function automatic logic [PC_W-1:0] pc_step(bdx_pkg::bdx_op_t op,
                                              bdx_pkg::bdx_amode_t m);
    logic [PC_W-1:0] s;
    s = PC_W'(bdx_pkg::PC_STEP_SHORT);
    if ((op == bdx_pkg::op_load || op == bdx_pkg::op_store) &&
        m == bdx_pkg::am_direct) begin
      s = PC_W'(bdx_pkg::PC_STEP_LONG); // address operand is a word
    end
    return s;
  endfunction : pc_step

  // feed the address unit from the request and current state
  always_comb begin
    accept = instr_valid && instr_ready;
    ptr_lo = ptr_base(instr_ptr);
    uses_ptr = (instr_op == bdx_pkg::op_load ||
                instr_op == bdx_pkg::op_store) &&
               instr_mode != bdx_pkg::am_direct;
    agu_bus.op = instr_op;
    agu_bus.mode = instr_mode;
    agu_bus.cond = instr_cond;
    agu_bus.ptr = {regs[ptr_lo + 5'h01], regs[ptr_lo]};
    agu_bus.sp = sp;
    agu_bus.addr = instr_addr;
    agu_bus.disp = instr_disp;
    agu_bus.offset = instr_offset;
    agu_bus.flags = flags; // read only, the core never writes flags
    agu_bus.pc = pc;
  end

  bdx_agu #(.PC_W(PC_W)) u_agu (
    .a(agu_bus.agu)
  );

  // sequencing, pc, stack pointer and memory strobes
  always_comb begin
    next_state = state;
    next_held_op = held_op;
    next_held_rd = held_rd;
    next_held_target = held_target;
    next_pc = pc;
    next_sp = sp;
    next_done = 1'b0;
    next_mem_we = 1'b0; // strobes are one-clock pulses
    next_mem_re = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    unique case (state)
      bdx_pkg::ph_idle: begin
        if (accept) begin
          next_held_op = instr_op;
          next_held_rd = instr_rd;
          unique case (instr_op)
            bdx_pkg::op_branch: begin
              if (agu_bus.taken) begin
                // fetched follower is dropped, land in second clock
                next_held_target = agu_bus.target;
                next_state = bdx_pkg::ph_second;
              end else begin
                next_pc = pc + PC_W'(bdx_pkg::PC_STEP_SHORT);
                next_done = 1'b1;
              end
            end
            bdx_pkg::register_copy: begin
              next_pc = pc + PC_W'(bdx_pkg::PC_STEP_SHORT);
              next_done = 1'b1;
            end
            bdx_pkg::op_load, bdx_pkg::op_pop: begin
              next_mem_addr = agu_bus.ea;
              next_mem_re = 1'b1;
              next_sp = agu_bus.sp_next;
              next_pc = pc + pc_step(instr_op, instr_mode);
              next_state = bdx_pkg::ph_second;
            end
            bdx_pkg::op_store, bdx_pkg::op_push: begin
              next_mem_addr = agu_bus.ea;
              next_mem_wdata = regs[instr_rr];
              next_mem_we = 1'b1;
              next_sp = agu_bus.sp_next;
              next_pc = pc + pc_step(instr_op, instr_mode);
              next_state = bdx_pkg::ph_second;
            end
            default: begin
              next_pc = pc + PC_W'(bdx_pkg::PC_STEP_SHORT); // no operation
              next_done = 1'b1;
            end
          endcase
        end
      end
      bdx_pkg::ph_second: begin
        // second clock of every two-clock instruction
        if (held_op == bdx_pkg::op_branch) begin
          next_pc = held_target;
        end
        next_done = 1'b1;
        next_state = bdx_pkg::ph_idle;
      end
    endcase
    next_ready = (next_state == bdx_pkg::ph_idle);
  end

  // working register writes and the observation port
  always_comb begin
    next_regs = regs;
    if (state == bdx_pkg::ph_second &&
        (held_op == bdx_pkg::op_load || held_op == bdx_pkg::op_pop)) begin
      // memory answers in the same clock as the read strobe
      next_regs[held_rd] = mem_rdata;
    end else if (accept && instr_op == bdx_pkg::register_copy) begin
      next_regs[instr_rd] = regs[instr_rr];
    end else if (accept && uses_ptr) begin
      // plain and offset modes write the pair back unchanged
      next_regs[ptr_lo] = agu_bus.ptr_next[7:0];
      next_regs[ptr_lo + 5'h01] = agu_bus.ptr_next[15:8];
    end else if (rf_wr_en && state == bdx_pkg::ph_idle && !accept) begin
      // outside loading only while the core is quiet
      next_regs[rf_wr_addr] = rf_wr_data;
    end
    next_rf_rd_data = regs[rf_rd_addr];
  end

  // register every next value
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < bdx_pkg::REG_N; i++) begin
        regs[i] <= bdx_pkg::REG_RESET;
      end
      state <= bdx_pkg::ph_idle;
      held_op <= bdx_pkg::op_nop;
      held_rd <= 5'h00;
      held_target <= '0;
      instr_ready <= 1'b0; // ready rises on the first edge after release
      done <= 1'b0;
      pc <= PC_RESET;
      sp <= bdx_pkg::SP_RESET;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      rf_rd_data <= 8'h00;
    end else begin
      regs <= next_regs;
      state <= next_state;
      held_op <= next_held_op;
      held_rd <= next_held_rd;
      held_target <= next_held_target;
      instr_ready <= next_ready;
      done <= next_done;
      pc <= next_pc;
      sp <= next_sp;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      mem_we <= next_mem_we;
      mem_re <= next_mem_re;
      rf_rd_data <= next_rf_rd_data;
    end
  end
endmodule : bdx_exec
`default_nettype wire

// ---- bench/bdx_mem_model.sv ----
// behavioural data memory and stack space facing the core
`timescale 1ns/100ps
`default_nettype none
module bdx_mem_model (
  input wire logic clock,
  input wire logic [bdx_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [bdx_pkg::DATA_W-1:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [bdx_pkg::DATA_W-1:0] mem_rdata
);
  logic [bdx_pkg::DATA_W-1:0] ram [0:65535]; // whole data space
  logic [bdx_pkg::DATA_W-1:0] last = 8'h00; // last byte handed out
  // write lands at the edge closing the write cycle
  always @(posedge clock) begin
    if (mem_we) begin
      ram[mem_addr] <= mem_wdata;
    end
    if (mem_re) begin
      last <= ram[mem_addr];
    end
  end
  // data only in the read cycle; inverted otherwise so stale bytes fail
  assign mem_rdata = mem_re ? ram[mem_addr] : ~last;
endmodule : bdx_mem_model
`default_nettype wire

// ---- bench/bdx_exec_sva.sv ----
// port checks for the branch and data transfer core
`timescale 1ns/100ps
`default_nettype none
module bdx_exec_sva #(
  parameter int PC_W = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic instr_valid,
  input wire bdx_pkg::bdx_op_t instr_op,
  input wire bdx_pkg::bdx_cond_t instr_cond,
  input wire bdx_pkg::bdx_amode_t instr_mode,
  input wire logic [bdx_pkg::ADDR_W-1:0] instr_addr,
  input wire logic [bdx_pkg::OFS_W-1:0] instr_offset,
  input wire logic [7:0] flags,
  input wire logic instr_ready,
  input wire logic done,
  input wire logic [PC_W-1:0] pc,
  input wire logic [bdx_pkg::ADDR_W-1:0] sp,
  input wire logic [bdx_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_we,
  input wire logic mem_re
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic take; // request accepted at this edge
  assign take = instr_valid && instr_ready;
  // busy cycle, then completion with ready back
  sequence two_clk;
    !instr_ready && !done ##1 done && instr_ready;
  endsequence
  copy_one_clk_a: assert property (
    take && instr_op == bdx_pkg::register_copy
    |=> done && instr_ready && pc == $past(pc) + 1'b1)
    else $error("copy not done in one clock");
  load_two_clk_a: assert property (
    take && instr_op == bdx_pkg::op_load
    |=> (mem_re && !mem_we) ##0 two_clk)
    else $error("load sequence wrong");
  store_two_clk_a: assert property (
    take && instr_op == bdx_pkg::op_store
    |=> (mem_we && !mem_re) ##0 two_clk)
    else $error("store sequence wrong");
  push_addr_a: assert property (take && instr_op == bdx_pkg::op_push
    |=> mem_we && mem_addr == $past(sp) && sp == $past(sp) - 1'b1)
    else $error("push address or stack pointer wrong");
  pop_addr_a: assert property (take && instr_op == bdx_pkg::op_pop
    |=> mem_re && mem_addr == $past(sp) + 1'b1 && sp == mem_addr)
    else $error("pop address or stack pointer wrong");
  direct_addr_a: assert property (
    take && instr_mode == bdx_pkg::am_direct
    && (instr_op == bdx_pkg::op_load || instr_op == bdx_pkg::op_store)
    |=> mem_addr == $past(instr_addr) && pc == $past(pc) + 2'h2)
    else $error("direct address wrong");
  carry_untaken_a: assert property (
    take && instr_op == bdx_pkg::op_branch
    && instr_cond == bdx_pkg::branch_carry_clear && flags[bdx_pkg::F_CARRY]
    |=> done && instr_ready && pc == $past(pc) + 1'b1)
    else $error("untaken branch wrong");
  lower_taken_a: assert property (
    take && instr_op == bdx_pkg::op_branch
    && instr_cond == bdx_pkg::branch_lower && flags[bdx_pkg::F_CARRY]
    |=> two_clk ##0 pc == $past(pc, 2)
      + PC_W'($signed($past(instr_offset, 2))) + 1'b1)
    else $error("taken branch wrong");
  mem_pulse_a: assert property (mem_we || mem_re
    |=> !mem_we && !mem_re)
    else $error("memory strobe longer than one cycle");
endmodule : bdx_exec_sva
bind bdx_exec bdx_exec_sva #(.PC_W(PC_W)) u_sva (.clock(clock), .srst(srst),
  .instr_valid(instr_valid), .instr_op(instr_op), .instr_cond(instr_cond),
  .instr_mode(instr_mode), .instr_addr(instr_addr),
  .instr_offset(instr_offset), .flags(flags), .instr_ready(instr_ready),
  .done(done), .pc(pc), .sp(sp), .mem_addr(mem_addr), .mem_we(mem_we),
  .mem_re(mem_re));
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the branch and data transfer core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 1'b0; // system clock
  logic srst = 1'b1; // synchronous reset
  logic instr_valid = 1'b0;
  bdx_pkg::bdx_op_t instr_op = bdx_pkg::op_nop;
  bdx_pkg::bdx_cond_t instr_cond = bdx_pkg::branch_carry_clear;
  bdx_pkg::bdx_amode_t instr_mode = bdx_pkg::am_plain;
  logic [1:0] instr_ptr = 2'h0;
  logic [4:0] instr_rd = 5'h00;
  logic [4:0] instr_rr = 5'h00;
  logic [5:0] instr_disp = 6'h00;
  logic [15:0] instr_addr = 16'h0000;
  logic [6:0] instr_offset = 7'h00;
  logic [7:0] flags = 8'h00;
  logic rf_wr_en = 1'b0;
  logic [4:0] rf_wr_addr = 5'h00;
  logic [7:0] rf_wr_data = 8'h00;
  logic [4:0] rf_rd_addr = 5'h00;
  logic instr_ready, done, mem_we, mem_re;
  logic [15:0] pc, sp, mem_addr;
  logic [7:0] mem_wdata, mem_rdata, rf_rd_data;
  int failures = 0;
  int n_checks = 0;
  int cyc; // cycles from take to done
  always #4 clock = ~clock;
  bdx_exec uut (.clock(clock), .srst(srst), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_cond(instr_cond), .instr_mode(instr_mode),
    .instr_ptr(instr_ptr), .instr_rd(instr_rd), .instr_rr(instr_rr),
    .instr_disp(instr_disp), .instr_addr(instr_addr),
    .instr_offset(instr_offset), .flags(flags), .mem_rdata(mem_rdata),
    .rf_wr_en(rf_wr_en), .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data),
    .rf_rd_addr(rf_rd_addr), .instr_ready(instr_ready), .done(done),
    .pc(pc), .sp(sp), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .rf_rd_data(rf_rd_data));
  bdx_mem_model mem (.clock(clock), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_rdata(mem_rdata));
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got,
        exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // request held until the take edge, then count cycles to done
  task automatic go(input bdx_pkg::bdx_op_t op, input bdx_pkg::bdx_amode_t m,
      input logic [1:0] p, input logic [4:0] rd, input logic [4:0] rr,
      input logic [15:0] a,
      input bdx_pkg::bdx_cond_t c = bdx_pkg::branch_carry_clear,
      input logic [6:0] o = 7'h00, input logic [7:0] f = 8'h00);
    @(posedge clock);
    instr_op <= op;
    instr_mode <= m;
    instr_ptr <= p;
    instr_rd <= rd;
    instr_rr <= rr;
    instr_addr <= a;
    instr_disp <= a[5:0];
    instr_cond <= c;
    instr_offset <= o;
    flags <= f;
    instr_valid <= 1'b1;
    do @(posedge clock); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    cyc = 0;
    do begin
      @(negedge clock);
      cyc++;
    end while (done !== 1'b1 && cyc < 4);
  endtask : go
  // memory instruction, always two clocks
  task automatic mop(input bdx_pkg::bdx_op_t op, input bdx_pkg::bdx_amode_t m,
      input logic [1:0] p, input logic [4:0] rd, input logic [4:0] rr,
      input logic [15:0] a);
    go(op, m, p, rd, rr, a);
    check(16'(cyc), 16'h0002, "memory op clocks");
  endtask : mop
  task automatic wr(input logic [4:0] r, input logic [7:0] d);
    @(posedge clock);
    rf_wr_en <= 1'b1;
    rf_wr_addr <= r;
    rf_wr_data <= d;
    @(posedge clock);
    rf_wr_en <= 1'b0;
  endtask : wr
  // read one register through the observation port
  task automatic creg(input logic [4:0] r, input logic [15:0] e,
      input string what);
    @(posedge clock);
    rf_rd_addr <= r;
    @(posedge clock);
    @(negedge clock);
    check(16'(rf_rd_data), e, what);
  endtask : creg
  // pointer pair checked as its two bytes
  task automatic cptr(input logic [4:0] lo, input logic [15:0] e);
    creg(lo, 16'(e[7:0]), "pointer low");
    creg(lo + 5'h01, 16'(e[15:8]), "pointer high");
  endtask : cptr
  function automatic logic taken(input logic [3:0] c, input logic [7:0] f);
    case (c)
      4'h0, 4'h1: taken = !f[0];
      4'h2: taken = f[0];
      4'h3, 4'h4: taken = f[2] ^ (c == 4'h4);
      4'h5, 4'h6: taken = f[2] ^ f[3] ^ (c == 4'h5);
      4'h7, 4'h8: taken = f[5] ^ (c == 4'h8);
      4'h9, 4'ha: taken = f[6] ^ (c == 4'ha);
      4'hb, 4'hc: taken = f[3] ^ (c == 4'hc);
      4'hd, 4'he: taken = f[7] ^ (c == 4'he);
      default: taken = 1'b0;
    endcase
  endfunction : taken
  // every condition code against clear, set and negative-only flags
  task automatic t_branch;
    logic [7:0] fl;
    logic [6:0] o;
    logic [15:0] exp;
    logic tk;
    for (int i = 0; i < 48; i++) begin
      fl = (i % 3 == 0) ? 8'h00 : ((i % 3 == 1) ? 8'hff : 8'h04);
      o = i[0] ? 7'h40 : 7'h3f;
      tk = taken(4'(i / 3), fl);
      exp = pc + (tk ? {{9{o[6]}}, o} + 16'h0001 : 16'h0001);
      go(bdx_pkg::op_branch, bdx_pkg::am_plain, 2'h0, 5'h00, 5'h00,
        16'h0000, bdx_pkg::bdx_cond_t'(4'(i / 3)), o, fl);
      check(16'(cyc), tk ? 16'h0002 : 16'h0001, "branch clocks");
      check(pc, exp, "pc");
    end
    $display("branch test finished");
  endtask : t_branch
  task automatic t_copy;
    logic [15:0] pc0;
    wr(5'h03, 8'ha5);
    pc0 = pc;
    go(bdx_pkg::register_copy, bdx_pkg::am_plain, 2'h0, 5'h05, 5'h03,
      16'h0000);
    check(16'(cyc), 16'h0001, "copy clocks");
    check(pc, pc0 + 16'h0001, "copy pc");
    go(bdx_pkg::op_nop, bdx_pkg::am_plain, 2'h0, 5'h05, 5'h01, 16'h0000);
    check(pc, pc0 + 16'h0002, "nop pc");
    creg(5'h05, 16'h00a5, "copy dest");
    $display("copy test finished");
  endtask : t_copy
  // post-increment and pre-decrement on all three pointer pairs
  task automatic t_ptr;
    logic [4:0] lo;
    logic [15:0] b;
    for (int p = 0; p < 3; p++) begin
      lo = 5'h1a + 5'(2 * p);
      b = 16'h0120 + 16'(16 * p);
      wr(lo, b[7:0]);
      wr(lo + 5'h01, b[15:8]);
      mop(bdx_pkg::op_store, bdx_pkg::am_post_inc, 2'(p), 0, 5'h01, 0);
      mop(bdx_pkg::op_store, bdx_pkg::am_post_inc, 2'(p), 0, 5'h02, 0);
      cptr(lo, b + 16'h0002);
      mop(bdx_pkg::op_load, bdx_pkg::am_pre_dec, 2'(p), 5'h04, 0, 0);
      mop(bdx_pkg::op_load, bdx_pkg::am_pre_dec, 2'(p), 5'h05, 0, 0);
      creg(5'h04, 16'h00c3, "pre-dec load");
      creg(5'h05, 16'h005a, "pre-dec load");
      cptr(lo, b);
      mop(bdx_pkg::op_load, bdx_pkg::am_post_inc, 2'(p), 5'h06, 0, 0);
      creg(5'h06, 16'h005a, "post-inc load");
      cptr(lo, b + 16'h0001);
      mop(bdx_pkg::op_store, bdx_pkg::am_pre_dec, 2'(p), 0, 5'h02, 0);
      mop(bdx_pkg::op_load, bdx_pkg::am_plain, 2'(p), 5'h07, 0, 0);
      creg(5'h07, 16'h00c3, "pre-dec store");
      cptr(lo, b);
    end
    $display("pointer test finished");
  endtask : t_ptr
  // displacement at its top value and direct addressing
  task automatic t_disp;
    logic [15:0] pc0;
    wr(5'h1c, 8'h00);
    wr(5'h1d, 8'h02);
    wr(5'h1e, 8'hc1);
    wr(5'h1f, 8'h02);
    mop(bdx_pkg::op_store, bdx_pkg::am_with_offset, 2'h1, 0, 5'h01, 16'h003f);
    pc0 = pc;
    mop(bdx_pkg::op_load, bdx_pkg::am_direct, 2'h0, 5'h08, 0, 16'h023f);
    check(pc, pc0 + 16'h0002, "direct pc");
    creg(5'h08, 16'h005a, "offset store");
    mop(bdx_pkg::op_store, bdx_pkg::am_direct, 2'h0, 0, 5'h02, 16'h0300);
    mop(bdx_pkg::op_load, bdx_pkg::am_with_offset, 2'h2, 5'h09, 0, 16'h003f);
    creg(5'h09, 16'h00c3, "offset load");
    cptr(5'h1c, 16'h0200);
    cptr(5'h1e, 16'h02c1);
    $display("displacement test finished");
  endtask : t_disp
  task automatic t_stack;
    mop(bdx_pkg::op_push, bdx_pkg::am_plain, 2'h0, 0, 5'h01, 0);
    check(sp, 16'h00fe, "sp after push");
    mop(bdx_pkg::op_push, bdx_pkg::am_plain, 2'h0, 0, 5'h02, 0);
    mop(bdx_pkg::op_pop, bdx_pkg::am_plain, 2'h0, 5'h0a, 0, 0);
    mop(bdx_pkg::op_pop, bdx_pkg::am_plain, 2'h0, 5'h0b, 0, 0);
    creg(5'h0a, 16'h00c3, "pop order");
    creg(5'h0b, 16'h005a, "pop order");
    check(sp, bdx_pkg::SP_RESET, "sp restored");
    $display("stack test finished");
  endtask : t_stack
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    wr(5'h01, 8'h5a);
    wr(5'h02, 8'hc3);
    t_branch();
    t_copy();
    t_ptr();
    t_disp();
    t_stack();
    final_report();
  end
  // watchdog: the tests need well under a tenth of this span
  initial begin
    #200000;
    failures++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
